// ===== core/wcg_watchdog_config_write_guard.sv
/*
 * Watchdog configuration write guard: an APB slave holding the watchdog
 * mode and enable registers, policing how software writes them and
 * raising an internal reset on illegal access.
 * Assumes an APB master on clk_sys; 1-bit manipulations of the mode and
 * enable registers arrive as writes to their bit-operation aliases.
 */
// Behaviour
// - after reset the mode register takes exactly one write, byte-wide only
// - a second mode-register write raises the internal reset
// - first write with upper clock-select set stops watchdog; rewrites then harmless
// - when stopped, a 1-bit manipulation of the enable register is harmless
// - when stopped, a non-key value to the enable register is harmless
// - the mode register never loads from a 1-bit manipulation
// - non-key enable write resets; enable register reads a fixed non-key value
module wcg_watchdog_config_write_guard
   import wcg_pkg::*;
#(
   parameter int PULSE_CYCLES = RST_PULSE_CYCLES,
   parameter int COUNT_W      = WD_COUNT_W
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire logic [APB_ADDR_W-1:0]   paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [APB_DATA_W-1:0]   pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [APB_DATA_W-1:0]   prdata,
   output logic                         pready,
   output logic                         pslverr,
   output logic                         intReset,
   output logic      [COUNT_W-1:0]      wdCount
);

   function automatic logic regHit(
      input logic [APB_ADDR_W-1:0] addr,
      input logic [7:0]            offset
   );
      regHit = (addr == APB_ADDR_W'(offset));
   endfunction : regHit

   function automatic logic mapped(input logic [APB_ADDR_W-1:0] addr);
      mapped = regHit(addr, OFF_MODE) || regHit(addr, OFF_ENABLE) || regHit(addr, OFF_MODE_BIT)
               || regHit(addr, OFF_ENABLE_BIT) || regHit(addr, OFF_STATUS);
   endfunction : mapped

   wcg_reset_if rstIf ();

   wcg_guard_state_t        guard_reg;
   logic [7:0]              mode_reg;
   logic                    patternBad_reg;
   logic [CAUSE_W-1:0]      cause_reg;
   logic [CAUSE_W-1:0]      cause_next;
   logic [COUNT_W-1:0]      count_reg;
   logic [APB_DATA_W-1:0]   prdata_reg;
   logic                    pready_reg;
   logic                    pslverr_reg;
   logic                    intReset_reg;

   logic                    access;
   logic                    wrAccess;
   logic                    byteLane;
   logic                    stopped;
   logic                    modeByteWr;
   logic                    modeBitWr;
   logic                    enableByteWr;
   logic                    enableBitWr;
   logic                    keyWr;
   logic                    statusWr;
   logic [CAUSE_W-1:0]      violation;
   logic [APB_DATA_W-1:0]   readValue;

   // access phase completes on the cycle pready is high
   assign access   = psel && penable && pready_reg;
   assign wrAccess = access && pwrite && !pslverr_reg;
   assign byteLane = pstrb[0];
   assign stopped  = (guard_reg == GUARD_STOPPED);

   // a mode or enable byte write with lane 0 off carries no byte and has no effect
   assign modeByteWr   = wrAccess && regHit(paddr, OFF_MODE) && byteLane;
   assign modeBitWr    = wrAccess && regHit(paddr, OFF_MODE_BIT);
   assign enableByteWr = wrAccess && regHit(paddr, OFF_ENABLE) && byteLane;
   assign enableBitWr  = wrAccess && regHit(paddr, OFF_ENABLE_BIT);
   assign keyWr        = enableByteWr && (pwdata[7:0] == ENABLE_KEY);
   assign statusWr     = wrAccess && regHit(paddr, OFF_STATUS);

   always_comb begin
      violation = '0;
      if (!stopped && !rstIf.active) begin
         violation[CAUSE_MODE_AGAIN] = modeByteWr && (guard_reg == GUARD_LOCKED);
         violation[CAUSE_MODE_BIT]   = modeBitWr;
         violation[CAUSE_ENABLE_VAL] = enableByteWr && !keyWr;
         violation[CAUSE_ENABLE_BIT] = enableBitWr;
      end
   end

   assign rstIf.fire = |violation;

   wcg_reset_stretch #(
      .CYCLES (PULSE_CYCLES)
   ) uStretch (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .rstIf   (rstIf)
   );

   // internal reset returns the guard to its post-reset state
   always_ff @(posedge clk_sys) begin
      if (!rst_b || rstIf.active) begin
         guard_reg <= GUARD_OPEN;
      end else begin
         unique case (guard_reg)
            GUARD_OPEN: begin
               if (modeByteWr) begin
                  if (pwdata[MODE_CS_HI_POS]) begin
                     guard_reg <= GUARD_STOPPED;
                  end else begin
                     guard_reg <= GUARD_LOCKED;
                  end
               end
            end
            GUARD_LOCKED: begin
               guard_reg <= GUARD_LOCKED;
            end
            GUARD_STOPPED: begin
               guard_reg <= GUARD_STOPPED;
            end
            default: begin
               guard_reg <= GUARD_OPEN;
            end
         endcase
      end
   end

   // only the first byte write loads; a later one loads nothing, but while locked it clears the setting via the internal reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b || rstIf.active) begin
         mode_reg <= MODE_RESET_VALUE;
      end else if (modeByteWr && (guard_reg == GUARD_OPEN)) begin
         mode_reg <= pwdata[7:0];
      end
   end

   // flags software misuse of the fixed top bits, no other effect
   always_ff @(posedge clk_sys) begin
      if (!rst_b || rstIf.active) begin
         patternBad_reg <= 1'b0;
      end else if (modeByteWr && (guard_reg == GUARD_OPEN)) begin
         patternBad_reg <= (pwdata[7:MODE_TOP_LSB] != MODE_TOP_PATTERN);
      end
   end

   // cause flags survive the internal reset so software can find why
   always_comb begin
      cause_next = cause_reg;
      if (statusWr && byteLane) begin
         cause_next = cause_next & ~pwdata[STAT_CAUSE_LSB +: CAUSE_W];
      end
      cause_next = cause_next | violation;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cause_reg <= '0;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // counter runs once configured and not stopped; it wraps to zero on overflow
   always_ff @(posedge clk_sys) begin
      if (!rst_b || rstIf.active) begin
         count_reg <= '0;
      end else if (keyWr && !stopped) begin
         count_reg <= '0;
      end else if (guard_reg == GUARD_LOCKED) begin
         count_reg <= count_reg + COUNT_W'(1);
      end
   end

   always_comb begin
      readValue = '0;
      if (regHit(paddr, OFF_MODE)) begin
         readValue[7:0] = mode_reg;
      end else if (regHit(paddr, OFF_ENABLE)) begin
         readValue[7:0] = ENABLE_READ_VALUE;
      end else if (regHit(paddr, OFF_STATUS)) begin
         readValue[STAT_LOCKED_POS]               = (guard_reg != GUARD_OPEN);
         readValue[STAT_STOPPED_POS]              = stopped;
         readValue[STAT_PATTERN_POS]              = patternBad_reg;
         readValue[STAT_CAUSE_LSB +: CAUSE_W]     = cause_reg;
         readValue[STAT_COUNT_LSB +: COUNT_W]     = count_reg;
      end
   end

   // one wait-free access cycle: answer loaded at the setup edge
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= psel && !penable;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pslverr_reg <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_reg <= !mapped(paddr);
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         prdata_reg <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= readValue;
      end else begin
         prdata_reg <= '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         intReset_reg <= 1'b0;
      end else begin
         intReset_reg <= rstIf.active;
      end
   end

   assign prdata   = prdata_reg;
   assign pready   = pready_reg;
   assign pslverr  = pslverr_reg;
   assign intReset = intReset_reg;
   assign wdCount  = count_reg;

endmodule : wcg_watchdog_config_write_guard

// ===== core/wcg_pkg.sv
/*
 * Constants and types for the watchdog configuration write guard:
 * register offsets, field positions, reset values, the guard states.
 * Assumes a 32-bit APB slave whose registers each take one aligned word.
 */
package wcg_pkg;

   localparam int          APB_ADDR_W        = 8;
   localparam int          APB_DATA_W        = 32;

   localparam logic [7:0]  OFF_MODE          = 8'h00;
   localparam logic [7:0]  OFF_ENABLE        = 8'h04;
   localparam logic [7:0]  OFF_MODE_BIT      = 8'h08;
   localparam logic [7:0]  OFF_ENABLE_BIT    = 8'h0c;
   localparam logic [7:0]  OFF_STATUS        = 8'h10;

   localparam logic [7:0]  ENABLE_KEY        = 8'hac;
   localparam logic [7:0]  ENABLE_READ_VALUE = 8'h9a;

   localparam logic [7:0]  MODE_RESET_VALUE  = 8'h00;
   localparam int          MODE_CS_HI_POS    = 4;
   localparam int          MODE_CS_LO_POS    = 3;
   localparam int          MODE_TOP_LSB      = 5;
   localparam logic [2:0]  MODE_TOP_PATTERN  = 3'h3;

   localparam int          STAT_LOCKED_POS   = 0;
   localparam int          STAT_STOPPED_POS  = 1;
   localparam int          STAT_PATTERN_POS  = 2;
   localparam int          STAT_CAUSE_LSB    = 4;
   localparam int          STAT_COUNT_LSB    = 16;

   localparam int          CAUSE_MODE_AGAIN  = 0;
   localparam int          CAUSE_MODE_BIT    = 1;
   localparam int          CAUSE_ENABLE_VAL  = 2;
   localparam int          CAUSE_ENABLE_BIT  = 3;
   localparam int          CAUSE_W           = 4;

   localparam int          RST_PULSE_CYCLES  = 4;
   localparam int          WD_COUNT_W        = 16;

   typedef enum logic [2:0] {
      GUARD_OPEN    = 3'h1,
      GUARD_LOCKED  = 3'h2,
      GUARD_STOPPED = 3'h4
   } wcg_guard_state_t;

endpackage : wcg_pkg

// ===== core/wcg_reset_if.sv
/*
 * Link between the write guard and its internal reset stretcher.
 * Assumes both ends run on the same system clock.
 */
interface wcg_reset_if;
   logic fire;
   logic active;

   modport ctrl (output fire, input active);
   modport gen  (input fire, output active);
endinterface : wcg_reset_if

// ===== core/wcg_reset_stretch.sv
/*
 * Stretches a one-cycle reset request into an internal reset level of
 * CYCLES clocks; a new request restarts the count.
 * Assumes clk_sys and a synchronous active-low rst_b.
 */
module wcg_reset_stretch
   import wcg_pkg::*;
#(
   parameter int CYCLES = RST_PULSE_CYCLES
) (
   input  wire logic    clk_sys,
   input  wire logic    rst_b,
   wcg_reset_if.gen     rstIf
);

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);

   logic [CNT_W-1:0] remain_reg;
   logic             active_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         remain_reg <= '0;
      end else if (rstIf.fire) begin
         remain_reg <= CNT_LOAD;
      end else if (remain_reg != '0) begin
         remain_reg <= remain_reg - CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         active_reg <= 1'b0;
      end else begin
         active_reg <= rstIf.fire || (remain_reg > CNT_W'(1));
      end
   end

   assign rstIf.active = active_reg;

endmodule : wcg_reset_stretch

// ===== verification/wcg_guard_checker.sv
/*
 * Concurrent checks on the write guard's top-level ports.
 * Assumes binding to the guard top; bench avoids writes while intReset is high.
 */
module wcg_guard_checker
   import wcg_pkg::*;
#(
   parameter int PULSE_CYCLES = RST_PULSE_CYCLES,
   parameter int COUNT_W      = WD_COUNT_W
) (
   input wire logic                  clk_sys,
   input wire logic                  rst_b,
   input wire logic [APB_ADDR_W-1:0] paddr,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [APB_DATA_W-1:0] pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic [APB_DATA_W-1:0] prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  intReset,
   input wire logic [COUNT_W-1:0]    wdCount
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic       cfg;
   logic       stp;
   logic       acc;
   logic       viol;
   logic [3:0] hi;
   assign acc  = psel && penable && pready && pwrite && !intReset;
   assign viol = acc && !stp && ((paddr == OFF_MODE && pstrb[0] && cfg) || paddr == OFF_MODE_BIT
                 || (paddr == OFF_ENABLE && pstrb[0] && pwdata[7:0] != ENABLE_KEY) || paddr == OFF_ENABLE_BIT);
   // guard shadow, dropped by any reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b || intReset) begin
         cfg <= 1'b0;
         stp <= 1'b0;
      end else if (acc && paddr == OFF_MODE && pstrb[0] && !cfg) begin
         cfg <= 1'b1;
         stp <= pwdata[MODE_CS_HI_POS];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !intReset) hi <= 4'h0;
      else hi <= hi + 4'h1;
   end
   property p_ready; psel && !penable |=> pready; endproperty
   property p_once; pready |=> !pready; endproperty
   property p_err; psel && !penable && paddr > OFF_STATUS |=> pslverr && prdata == '0; endproperty
   property p_enrd; pready && !pwrite && paddr == OFF_ENABLE |-> prdata == {24'h0, ENABLE_READ_VALUE}; endproperty
   property p_viol; viol |-> ##2 intReset; endproperty
   property p_quiet; acc && stp |=> !intReset [*2]; endproperty
   property p_cause; $rose(intReset) |-> $past(viol, 2); endproperty
   property p_len; $fell(intReset) |-> hi == PULSE_CYCLES; endproperty
   property p_clr;
      acc && cfg && !stp && paddr == OFF_ENABLE && pstrb[0] && pwdata[7:0] == ENABLE_KEY |-> ##[1:2] (wdCount < 2);
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_once: assert property (p_once) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("unmapped access not flagged");
   a_enrd: assert property (p_enrd) else $error("enable read value wrong");
   a_viol: assert property (p_viol) else $error("illegal write did not reset");
   a_quiet: assert property (p_quiet) else $error("reset while stopped");
   a_cause: assert property (p_cause) else $error("reset without cause");
   a_len: assert property (p_len) else $error("reset pulse length wrong");
   a_clr: assert property (p_clr) else $error("key did not clear counter");
   c_viol: cover property (viol);
   c_quiet: cover property (acc && stp);
   c_fell: cover property ($fell(intReset));
endmodule : wcg_guard_checker

// ===== verification/wcg_cpu_model.sv
/*
 * CPU-side APB master model issuing byte and bit-alias writes and reads.
 * Assumes xfer is called just after a rising edge of clk_sys.
 */
module wcg_cpu_model
   import wcg_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  pready,
   output logic      [APB_ADDR_W-1:0] paddr,
   output logic                       psel,
   output logic                       penable,
   output logic                       pwrite,
   output logic      [APB_DATA_W-1:0] pwdata,
   output logic      [3:0]            pstrb
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {psel, penable, pwrite, pstrb, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_sys);
      {paddr, pwrite, pwdata, pstrb, psel, penable} <= {a, w, d, s, 2'b10};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!pready && n < 50);
      // released lines must not keep showing the old value
      {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
   endtask : xfer
endmodule : wcg_cpu_model

// ===== verification/watchdog_config_write_guard_bench.sv
/*
 * Self-checking bench for the watchdog configuration write guard.
 * Assumes the checker and CPU model files are compiled before this one.
 */
module watchdog_config_write_guard_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import wcg_pkg::*;
   logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, intReset, irPrev;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, v;
   logic [3:0]  pstrb;
   logic [15:0] wdCount;
   logic [63:0] rdq[$];
   logic [63:0] q;
   logic [7:0]  adr[4] = '{OFF_MODE, OFF_MODE_BIT, OFF_ENABLE, OFF_ENABLE_BIT};
   int          mismatches, tests_run, cyc, seed, pend;
   wcg_cpu_model cpu (.clk_sys(clk_sys), .pready(pready), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb));
   wcg_watchdog_config_write_guard #(.PULSE_CYCLES(2)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .intReset(intReset), .wdCount(wdCount));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic final_report();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bad);
      pend += bad;
      cpu.xfer(a, 1'b1, {24'h0, d}, 4'hf);
      if (bad) repeat (8) @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rdq.push_back({e, m});
      cpu.xfer(a, 1'b0, 32'h0, 4'hf);
   endtask : rd
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // result watcher: reads and internal reset pulses
   always @(posedge clk_sys) begin
      irPrev <= intReset;
      cyc++;
      if (rst_b && pready && !pwrite) begin
         q = rdq.pop_front();
         cmp(prdata & q[31:0], q[63:32]);
      end
      if (rst_b && intReset && !irPrev) begin
         cmp({31'h0, pend > 0}, 32'h1);
         pend--;
      end
      if (cyc == 4000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      seed = 3;
      rst_b = 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(OFF_ENABLE, 32'h9a, 32'hffffffff);
      rd(8'h40, 32'h0, 32'hffffffff);
      cpu.xfer(OFF_MODE, 1'b1, 32'h63, 4'he);
      rd(OFF_MODE, 32'h0, 32'hff);
      wr(OFF_MODE_BIT, 8'h10, 1'b1);
      rd(OFF_MODE, 32'h0, 32'hff);
      wr(OFF_MODE, 8'h62, 1'b0);
      rd(OFF_MODE, 32'h62, 32'hff);
      wr(OFF_ENABLE, ENABLE_KEY, 1'b0);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         if (v[7:0] == ENABLE_KEY) v[7:0] = 8'h55;
         // guard is still locked on the first pass, so only later passes rewrite mode
         if (i > 0) wr(OFF_MODE, 8'h62, 1'b0);
         wr(adr[i], v[7:0], 1'b1);
      end
      rd(OFF_STATUS, 32'hf0, 32'hf0);
      wr(OFF_STATUS, 8'hf0, 1'b0);
      rd(OFF_STATUS, 32'h0, 32'hf0);
      wr(OFF_MODE, {3'h3, 1'b1, v[3:0]}, 1'b0);
      rd(OFF_STATUS, 32'h2, 32'h2);
      for (int i = 0; i < 4; i++) wr(adr[i], v[7:0], 1'b0);
      rd(OFF_MODE, {24'h0, 3'h3, 1'b1, v[3:0]}, 32'hff);
      repeat (8) @(posedge clk_sys);
      cmp(32'(pend), 32'h0);
      cmp(32'(rdq.size()), 32'h0);
      final_report();
   end
endmodule : watchdog_config_write_guard_bench
bind wcg_watchdog_config_write_guard wcg_guard_checker #(.PULSE_CYCLES(PULSE_CYCLES), .COUNT_W(COUNT_W)) chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .intReset(intReset), .wdCount(wdCount));
